// >>> rtl/ulpi_pkg.sv
// Shared constants, types and helpers for both ends of the nibble-wide link.
package ulpi_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   // The interface clock is nominally 60 MHz. A 25 MHz system clock cannot
   // make that, so the divider produces a scaled clock with the same framing.
   localparam int CLK_PERIOD_NS    = 40;
   localparam int ULPI_NOMINAL_MHZ = 60;
   localparam int ULPI_PERIOD_NS   = 640;
   localparam int ULPI_HALF_CYCLES = ULPI_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int STARTUP_CYCLES   = 4;

   // ------------------------------------------------------------------
   // Widths, values and field positions
   // ------------------------------------------------------------------
   localparam int         NIBBLE_W    = 4;
   localparam int         BYTE_W      = 8;
   localparam logic [3:0] NIBBLE_ZERO = 4'h0;
   localparam logic [7:0] IDLE_BYTE   = 8'h00;
   localparam int         LP_INT_BIT  = 3;
   localparam int         LP_RSV_BIT  = 2;
   localparam int         LP_LS_MSB   = 1;

   // Kind of byte the device end puts on the bus while it owns it.
   typedef enum logic [1:0] {
      KIND_DATA    = 2'b00,
      KIND_RXCMD   = 2'b01,
      KIND_REGDATA = 2'b10
   } send_kind_type;

   // Low-power nibble: line state on lines 1:0, line 2 low, interrupt on line 3.
   function automatic logic [NIBBLE_W-1:0] lp_nibble(input logic [1:0] ls, input logic irq);
      logic [NIBBLE_W-1:0] n;
      n                  = NIBBLE_ZERO;
      n[LP_LS_MSB:0]     = ls;
      n[LP_RSV_BIT]      = 1'b0;
      n[LP_INT_BIT]      = irq;
      return n;
   endfunction : lp_nibble

endpackage : ulpi_pkg

// >>> rtl/ulpi_if.sv
// Nibble-wide link between the transceiver end and the link controller end.
`timescale 1ns/1ps
interface ulpi_if;
   logic                          ulpi_clk;
   logic                          dir;
   logic                          nxt;
   logic                          stp;
   logic [ulpi_pkg::NIBBLE_W-1:0] phy_data;
   logic                          phy_data_oe;
   logic [ulpi_pkg::NIBBLE_W-1:0] link_data;
   logic                          link_data_oe;
   logic [ulpi_pkg::NIBBLE_W-1:0] data;

   // Resolved level of the shared data lines; an undriven bus reads as zero.
   assign data = phy_data_oe ? phy_data : (link_data_oe ? link_data : ulpi_pkg::NIBBLE_ZERO);

   modport phy  (output ulpi_clk, dir, nxt, phy_data, phy_data_oe, input stp, data);
   modport link (input ulpi_clk, dir, nxt, data, output stp, link_data, link_data_oe);
endinterface : ulpi_if

// >>> rtl/ulpi_phy_end.sv
// Transceiver end of the link: clock source, bus direction, throttling and mode control.
//
// What this block and the link end do
// - Enters synchronous mode once interface clock runs.
// - Link samples every signal on interface clock.
// - Interface clock driven only while crystal present.
// - Link drives zero nibbles while idle.
// - Nonzero byte from link starts a transfer.
// - Direction low by default, high to send.
// - One turnaround cycle per direction change, ignored.
// - Low nibble on rising, high on falling.
// - Only whole bytes, never odd nibbles.
// - Direction and next high means USB data.
// - Next low shows status or register data.
// - Link stop pulses one cycle after last byte.
// - Stop while transceiver owns bus drops direction.
// - Next with direction low requests following byte.
// - Next high only with valid received data.
// - Direction held high in low-power modes.
// - Next unused in low-power modes.
// - Held stop returns bus to synchronous mode.
// - Low power entered when enter_low_power input is high.
// - Low power maps line state, zero, interrupt.
`timescale 1ns/1ps
module ulpi_phy_end #(
   parameter int HALF_CYCLES = ulpi_pkg::ULPI_HALF_CYCLES,
   parameter int STARTUP     = ulpi_pkg::STARTUP_CYCLES
) (
   input  wire logic                          clk,
   input  wire logic                          rst,
   ulpi_if.phy                                bus,
   input  wire logic                          crystal_present,
   input  wire logic                          enter_low_power,
   input  wire logic                          serial_mode,
   input  wire logic [1:0]                    line_state,
   input  wire logic                          interrupt_req,
   input  wire logic [ulpi_pkg::BYTE_W-1:0]   status_byte,
   input  wire logic                          send_valid,
   input  wire ulpi_pkg::send_kind_type       send_kind,
   input  wire logic [ulpi_pkg::BYTE_W-1:0]   send_byte,
   input  wire logic                          send_last,
   input  wire logic                          tx_ready,
   output logic                               send_taken,
   output logic                               rcv_valid,
   output logic                               rcv_cmd,
   output logic [ulpi_pkg::BYTE_W-1:0]        rcv_byte,
   output logic                               rcv_end,
   output logic                               abort_seen,
   output logic                               in_sync_mode
);
   import ulpi_pkg::*;

   typedef enum logic [2:0] {
      ST_START    = 3'b000,
      ST_IDLE     = 3'b001,
      ST_TURN_IN  = 3'b010,
      ST_SEND     = 3'b011,
      ST_TURN_OUT = 3'b100,
      ST_RECV     = 3'b101,
      ST_LOW      = 3'b110
   } phy_state_type;

   localparam int                DIV_W    = $clog2(HALF_CYCLES + 1);
   localparam logic [DIV_W-1:0]  DIV_LAST = DIV_W'(HALF_CYCLES - 1);
   localparam logic [DIV_W-1:0]  DIV_MID  = DIV_W'(HALF_CYCLES / 2 - 1);
   localparam logic [DIV_W-1:0]  DIV_ONE  = DIV_W'(1);
   localparam int                ST_W     = $clog2(STARTUP + 1);
   localparam logic [ST_W-1:0]   ST_LAST  = ST_W'(STARTUP - 1);
   localparam logic [ST_W-1:0]   ST_ONE   = ST_W'(1);
   localparam int                SYNC_W   = 9;

   phy_state_type         state;
   logic [SYNC_W-1:0]     sync_m;
   logic [SYNC_W-1:0]     sync_q;
   logic                  xtal_ok;
   logic [1:0]            ls_s;
   logic                  irq_s;
   logic                  stp_s;
   logic [NIBBLE_W-1:0]   dat_s;
   logic [DIV_W-1:0]      div_cnt;
   logic                  at_edge;
   logic                  tick_rise;
   logic                  tick_fall;
   logic                  launch_lo;
   logic                  launch_hi;
   logic [NIBBLE_W-1:0]   lo_nib;
   logic                  stp_r;
   logic [BYTE_W-1:0]     bus_byte;
   logic [BYTE_W-1:0]     lp_byte;
   logic                  nx_dir;
   logic                  nx_nxt;
   logic                  nx_oe;
   logic [BYTE_W-1:0]     nx_byte;
   logic [ST_W-1:0]       st_cnt;
   logic                  last_sent;
   logic                  first;
   logic                  lp_pending;

   // ------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------
   // Pins from the link and from the analog side pass two flops before use.
   always_ff @(posedge clk) begin
      if (rst) begin
         sync_m <= '0;
         sync_q <= '0;
      end else begin
         sync_m <= {crystal_present, line_state, interrupt_req, bus.stp, bus.data};
         sync_q <= sync_m;
      end
   end

   assign xtal_ok = sync_q[8];
   assign ls_s    = sync_q[7:6];
   assign irq_s   = sync_q[5];
   assign stp_s   = sync_q[4];
   assign dat_s   = sync_q[3:0];

   // ------------------------------------------------------------------
   // Interface clock divider
   // ------------------------------------------------------------------
   // Without a crystal the divider stands still, so no clock leaves the pin.
   always_ff @(posedge clk) begin
      if (rst) begin
         div_cnt      <= '0;
         bus.ulpi_clk <= 1'b0;
      end else if (xtal_ok) begin
         if (div_cnt == DIV_LAST) begin
            div_cnt      <= '0;
            bus.ulpi_clk <= ~bus.ulpi_clk;
         end else begin
            div_cnt <= div_cnt + DIV_ONE;
         end
      end
   end

   // Outputs change mid-phase so the far end sees them settled at each edge.
   assign at_edge   = xtal_ok && (div_cnt == DIV_LAST);
   assign tick_rise = at_edge && !bus.ulpi_clk;
   assign tick_fall = at_edge && bus.ulpi_clk;
   assign launch_lo = xtal_ok && (div_cnt == DIV_MID) && !bus.ulpi_clk;
   assign launch_hi = xtal_ok && (div_cnt == DIV_MID) && bus.ulpi_clk;

   // ------------------------------------------------------------------
   // Sampling of link-driven lines
   // ------------------------------------------------------------------
   // Low nibble and stop are taken at the rising edge, the high nibble at falling.
   always_ff @(posedge clk) begin
      if (rst) begin
         lo_nib <= NIBBLE_ZERO;
         stp_r  <= 1'b0;
      end else if (tick_rise) begin
         lo_nib <= dat_s;
         stp_r  <= stp_s;
      end
   end

   assign bus_byte = {dat_s, lo_nib};
   assign lp_byte  = {lp_nibble(ls_s, irq_s), lp_nibble(ls_s, irq_s)};

   // ------------------------------------------------------------------
   // Cycle sequencer
   // ------------------------------------------------------------------
   // Decides at each falling edge what the next interface cycle carries.
   always_ff @(posedge clk) begin
      if (rst) begin
         state        <= ST_START;
         nx_dir       <= 1'b1;
         nx_nxt       <= 1'b0;
         nx_oe        <= 1'b1;
         nx_byte      <= IDLE_BYTE;
         st_cnt       <= '0;
         last_sent    <= 1'b0;
         first        <= 1'b0;
         lp_pending   <= 1'b0;
         send_taken   <= 1'b0;
         rcv_valid    <= 1'b0;
         rcv_cmd      <= 1'b0;
         rcv_byte     <= IDLE_BYTE;
         rcv_end      <= 1'b0;
         abort_seen   <= 1'b0;
         in_sync_mode <= 1'b0;
      end else begin
         send_taken <= 1'b0;
         rcv_valid  <= 1'b0;
         rcv_end    <= 1'b0;
         abort_seen <= 1'b0;
         if (tick_fall) begin
            unique case (state)
               ST_START: begin
                  if (st_cnt == ST_LAST) begin
                     nx_dir <= 1'b0;
                     nx_oe  <= 1'b0;
                     state  <= ST_TURN_OUT;
                  end else begin
                     st_cnt <= st_cnt + ST_ONE;
                  end
               end
               ST_IDLE: begin
                  // Own traffic wins over a link that starts in the same cycle.
                  if (enter_low_power || serial_mode || send_valid) begin
                     nx_dir     <= 1'b1;
                     nx_oe      <= 1'b0;
                     nx_nxt     <= 1'b0;
                     lp_pending <= enter_low_power || serial_mode;
                     state      <= ST_TURN_IN;
                  end else if (bus_byte != IDLE_BYTE && !stp_r) begin
                     nx_nxt <= tx_ready;
                     first  <= 1'b1;
                     state  <= ST_RECV;
                  end
               end
               ST_TURN_IN: begin
                  nx_oe <= 1'b1;
                  if (lp_pending) begin
                     nx_byte      <= lp_byte;
                     in_sync_mode <= 1'b0;
                     state        <= ST_LOW;
                  end else begin
                     state <= ST_SEND;
                     if (send_valid) begin
                        nx_byte    <= send_byte;
                        nx_nxt     <= (send_kind == KIND_DATA);
                        last_sent  <= send_last;
                        send_taken <= 1'b1;
                     end else begin
                        nx_byte   <= status_byte;
                        nx_nxt    <= 1'b0;
                        last_sent <= 1'b0;
                     end
                  end
               end
               ST_SEND: begin
                  if (stp_r || last_sent) begin
                     abort_seen <= stp_r;
                     nx_dir     <= 1'b0;
                     nx_oe      <= 1'b0;
                     nx_nxt     <= 1'b0;
                     nx_byte    <= IDLE_BYTE;
                     state      <= ST_TURN_OUT;
                  end else if (send_valid) begin
                     nx_byte    <= send_byte;
                     nx_nxt     <= (send_kind == KIND_DATA);
                     last_sent  <= send_last;
                     send_taken <= 1'b1;
                  end else begin
                     nx_byte <= status_byte;
                     nx_nxt  <= 1'b0;
                  end
               end
               ST_TURN_OUT: begin
                  in_sync_mode <= 1'b1;
                  state        <= ST_IDLE;
               end
               ST_RECV: begin
                  // A byte counts only in a cycle where next was high.
                  if (bus.nxt && !stp_r) begin
                     rcv_valid <= 1'b1;
                     rcv_byte  <= bus_byte;
                     rcv_cmd   <= first;
                     first     <= 1'b0;
                  end
                  if (stp_r) begin
                     rcv_end <= 1'b1;
                     nx_nxt  <= 1'b0;
                     state   <= ST_IDLE;
                  end else begin
                     nx_nxt <= tx_ready;
                  end
               end
               ST_LOW: begin
                  // Line state is refreshed each cycle; it lags the pins by a cycle.
                  nx_nxt  <= 1'b0;
                  nx_byte <= lp_byte;
                  if (stp_r) begin
                     nx_dir <= 1'b0;
                     nx_oe  <= 1'b0;
                     state  <= ST_TURN_OUT;
                  end
               end
               default: begin
                  nx_dir <= 1'b0;
                  nx_oe  <= 1'b0;
                  state  <= ST_TURN_OUT;
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // Pin launch
   // ------------------------------------------------------------------
   // Direction is high through reset and low-power, blocking the link.
   always_ff @(posedge clk) begin
      if (rst) begin
         bus.dir         <= 1'b1;
         bus.nxt         <= 1'b0;
         bus.phy_data_oe <= 1'b1;
         bus.phy_data    <= NIBBLE_ZERO;
      end else if (launch_lo) begin
         bus.dir         <= nx_dir;
         bus.nxt         <= nx_nxt;
         bus.phy_data_oe <= nx_oe;
         bus.phy_data    <= nx_byte[3:0];
      end else if (launch_hi) begin
         bus.phy_data <= nx_byte[7:4];
      end
   end

endmodule : ulpi_phy_end

// >>> rtl/ulpi_link_end.sv
// Link controller end: idles the bus, sends commands and data, receives bytes.
`timescale 1ns/1ps
module ulpi_link_end (
   input  wire logic                        clk,
   input  wire logic                        rst,
   ulpi_if.link                             bus,
   input  wire logic                        tx_valid,
   input  wire logic [ulpi_pkg::BYTE_W-1:0] tx_byte,
   input  wire logic                        tx_last,
   input  wire logic                        abort_req,
   output logic                             tx_taken,
   output logic                             tx_dropped,
   output logic                             rx_valid,
   output logic [ulpi_pkg::BYTE_W-1:0]      rx_byte,
   output logic                             rx_is_data,
   output logic                             phy_owns_bus
);
   import ulpi_pkg::*;

   typedef enum logic {
      L_IDLE = 1'b0,
      L_SEND = 1'b1
   } link_state_type;

   link_state_type        state;
   logic [6:0]            sync_m;
   logic [6:0]            sync_q;
   logic                  clk_d;
   logic                  rise_seen;
   logic                  fall_seen;
   logic [NIBBLE_W-1:0]   lo_nib;
   logic                  dir_r;
   logic                  nxt_r;
   logic                  dir_prev;
   logic [BYTE_W-1:0]     cur;
   logic                  cur_last;
   logic                  launch_lo;

   // ------------------------------------------------------------------
   // Synchronisers and edge finder
   // ------------------------------------------------------------------
   // Clock and data share one delay, so data is read as it stood at the edge.
   always_ff @(posedge clk) begin
      if (rst) begin
         sync_m <= '0;
         sync_q <= '0;
         clk_d  <= 1'b0;
      end else begin
         sync_m <= {bus.ulpi_clk, bus.dir, bus.nxt, bus.data};
         sync_q <= sync_m;
         clk_d  <= sync_q[6];
      end
   end

   assign rise_seen = sync_q[6] && !clk_d;
   assign fall_seen = !sync_q[6] && clk_d;

   // Single-rate lines and the low nibble are taken at the rising edge.
   always_ff @(posedge clk) begin
      if (rst) begin
         lo_nib <= NIBBLE_ZERO;
         dir_r  <= 1'b1;
         nxt_r  <= 1'b0;
      end else if (rise_seen) begin
         lo_nib <= sync_q[3:0];
         dir_r  <= sync_q[5];
         nxt_r  <= sync_q[4];
      end
   end

   // ------------------------------------------------------------------
   // Cycle sequencer
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         state             <= L_IDLE;
         bus.stp           <= 1'b0;
         bus.link_data_oe  <= 1'b0;
         cur               <= IDLE_BYTE;
         cur_last          <= 1'b0;
         dir_prev          <= 1'b1;
         launch_lo         <= 1'b0;
         tx_taken          <= 1'b0;
         tx_dropped        <= 1'b0;
         rx_valid          <= 1'b0;
         rx_byte           <= IDLE_BYTE;
         rx_is_data        <= 1'b0;
         phy_owns_bus      <= 1'b1;
      end else begin
         tx_taken   <= 1'b0;
         tx_dropped <= 1'b0;
         rx_valid   <= 1'b0;
         launch_lo  <= 1'b0;
         if (fall_seen) begin
            dir_prev     <= dir_r;
            phy_owns_bus <= dir_r;
            if (dir_r) begin
               bus.stp          <= abort_req && dir_prev;
               bus.link_data_oe <= 1'b0;
               if (dir_prev) begin
                  rx_valid   <= 1'b1;
                  rx_byte    <= {sync_q[3:0], lo_nib};
                  rx_is_data <= nxt_r;
               end
               if (state == L_SEND) begin
                  tx_dropped <= 1'b1;
                  state      <= L_IDLE;
               end
            end else begin
               bus.stp          <= 1'b0;
               bus.link_data_oe <= 1'b1;
               launch_lo        <= 1'b1;
               unique case (state)
                  L_IDLE: begin
                     if (tx_valid) begin
                        cur      <= tx_byte;
                        cur_last <= tx_last;
                        tx_taken <= 1'b1;
                        state    <= L_SEND;
                     end else begin
                        cur <= IDLE_BYTE;
                     end
                  end
                  L_SEND: begin
                     if (nxt_r) begin
                        if (cur_last || !tx_valid) begin
                           cur     <= IDLE_BYTE;
                           bus.stp <= 1'b1;
                           state   <= L_IDLE;
                        end else begin
                           cur      <= tx_byte;
                           cur_last <= tx_last;
                           tx_taken <= 1'b1;
                        end
                     end
                  end
               endcase
            end
         end
         // Release as soon as direction rises, well before the turnaround edge.
         if (sync_q[5]) begin
            bus.link_data_oe <= 1'b0;
         end
      end
   end

   // Whole bytes only: both nibbles always come from the same held byte.
   always_ff @(posedge clk) begin
      if (rst) begin
         bus.link_data <= NIBBLE_ZERO;
      end else if (launch_lo) begin
         bus.link_data <= cur[3:0];
      end else if (rise_seen) begin
         bus.link_data <= cur[7:4];
      end
   end

endmodule : ulpi_link_end

// >>> dv/ulpi_chk.sv
// Assertion checker watching the wires between the two ends of the link.
`timescale 1ns/1ps
module ulpi_chk (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       ulpi_clk,
   input wire logic       dir,
   input wire logic       nxt,
   input wire logic       stp,
   input wire logic [3:0] data,
   input wire logic       phy_data_oe,
   input wire logic       link_data_oe
);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   // The link pins are slow beside the system clock, so it samples all of them.
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   one_driver_a: assert property (!(phy_data_oe && link_data_oe))
      else $error("both ends drive the data lines");
   link_off_a: assert property (dir && $past(dir, 4) |-> !link_data_oe)
      else $error("link drives while the transceiver owns the bus");
   phy_dir_a: assert property (phy_data_oe |-> dir)
      else $error("transceiver drives with direction low");
   turn_gap_a: assert property ($rose(dir) |-> !phy_data_oe [*8])
      else $error("data driven in the turnaround cycle");
   nxt_data_a: assert property (dir && nxt |-> phy_data_oe)
      else $error("next high without a driven data byte");
   stop_pulse_a: assert property ($rose(stp) && !dir |-> stp [*8] ##[1:12] !stp)
      else $error("stop is not a single cycle");
   stop_drop_a: assert property ($rose(stp) && dir |-> ##[1:48] !dir)
      else $error("direction kept high after stop");
   idle_zero_a: assert property (stp && $past(stp, 2) && !dir |-> data == 4'h0)
      else $error("data lines not zero after the last byte");
   clk_half_a: assert property ($changed(ulpi_clk) |=> $stable(ulpi_clk) [*7])
      else $error("interface clock half period too short");
   // Main scenarios reached.
   cover property ($rose(dir) ##[1:40] nxt);
   cover property (stp && dir);
   cover property ($rose(link_data_oe));
endmodule : ulpi_chk

// >>> dv/ulpi_synchronous_mode_port_test.sv
// Testbench joining both ends of the nibble link.
`timescale 1ns/1ps
module ulpi_synchronous_mode_port_test;
   import ulpi_pkg::*;
   logic          clk, rst, xtal, lp_req, irq, s_valid, s_last, t_valid, t_last, abort, ser;
   logic          s_taken, r_valid, r_cmd, r_end, ab_seen, sync, t_taken, rx_v, rx_d, owns, t_drop;
   logic [1:0]    ls;
   logic [7:0]    s_byte, t_byte, r_byte, rx_b;
   send_kind_type s_kind;
   logic [8:0]    prx[$], lrx[$];
   logic [8:0]    ex[5] = '{9'h1C3, 9'h196, 9'h15A, 9'h05B, 9'h05C};
   int            fails, n_compared, n_abort, n_end, n_drop;
   ulpi_if ulpi_if_inst ();
   ulpi_phy_end ulpi_phy_end_inst (.clk(clk), .rst(rst), .bus(ulpi_if_inst.phy), .crystal_present(xtal),
      .enter_low_power(lp_req), .serial_mode(ser), .line_state(ls), .interrupt_req(irq),
      .status_byte(8'h3C), .send_valid(s_valid), .send_kind(s_kind), .send_byte(s_byte),
      .send_last(s_last), .tx_ready(1'b1), .send_taken(s_taken), .rcv_valid(r_valid),
      .rcv_cmd(r_cmd), .rcv_byte(r_byte), .rcv_end(r_end), .abort_seen(ab_seen), .in_sync_mode(sync));
   ulpi_link_end ulpi_link_end_inst (.clk(clk), .rst(rst), .bus(ulpi_if_inst.link), .tx_valid(t_valid),
      .tx_byte(t_byte), .tx_last(t_last), .abort_req(abort), .tx_taken(t_taken), .tx_dropped(t_drop),
      .rx_valid(rx_v), .rx_byte(rx_b), .rx_is_data(rx_d), .phy_owns_bus(owns));
   ulpi_chk ulpi_chk_inst (.clk(clk), .rst(rst), .ulpi_clk(ulpi_if_inst.ulpi_clk), .dir(ulpi_if_inst.dir),
      .nxt(ulpi_if_inst.nxt), .stp(ulpi_if_inst.stp), .data(ulpi_if_inst.data),
      .phy_data_oe(ulpi_if_inst.phy_data_oe), .link_data_oe(ulpi_if_inst.link_data_oe));
   // ---------------------------------------------------------------
   // Clock, monitors and tasks
   // ---------------------------------------------------------------
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   // Pulses are caught at the falling edge, where they are settled; status filler is skipped.
   always @(negedge clk) begin
      if (r_valid === 1) prx.push_back({r_cmd, r_byte});
      if (rx_v === 1 && sync === 1 && {rx_d, rx_b} !== 9'h03C) lrx.push_back({rx_d, rx_b});
      if (ab_seen === 1) n_abort++;
      if (r_end === 1) n_end++;
      if (t_drop === 1) n_drop++;
   end
   task cmp(input logic [8:0] g, input logic [8:0] e);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask : cmp
   // Requests are held until the taken pulse is seen, then changed at the next rising edge.
   task psend(input send_kind_type k, input logic [7:0] b, input logic l);
      @(posedge clk);
      {s_valid, s_kind, s_byte, s_last} <= {1'b1, k, b, l};
      @(negedge clk);
      for (int i = 0; i < 400 && s_taken !== 1; i++) @(negedge clk);
      if (s_taken !== 1) fails++;
   endtask : psend
   task lsend(input logic [7:0] b, input logic l);
      @(posedge clk);
      {t_valid, t_byte, t_last} <= {1'b1, b, l};
      @(negedge clk);
      for (int i = 0; i < 400 && t_taken !== 1; i++) @(negedge clk);
      if (t_taken !== 1) fails++;
   endtask : lsend
   task give_verdict;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : give_verdict
   // A hang is cut short well past the thousand or so cycles the tests need.
   initial begin
      repeat (30000) @(posedge clk);
      fails++;
      give_verdict;
   end
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      {ser, rst, xtal, lp_req, irq, ls, s_valid, s_last, s_byte, t_valid, t_last, t_byte, abort} = 28'h4000000;
      s_kind = KIND_DATA;
      {fails, n_compared, n_abort, n_end, n_drop} = '0;
      repeat (6) @(posedge clk);
      rst <= 0;
      // No crystal yet, so the interface clock must stand still and the mode must not start.
      repeat (40) @(negedge clk);
      cmp({ulpi_if_inst.ulpi_clk, sync}, 9'h0);
      @(posedge clk) xtal <= 1;
      for (int i = 0; i < 2000 && sync !== 1; i++) @(negedge clk);
      cmp(ulpi_if_inst.dir, 9'h0);
      $display("test startup done");
      lsend(8'h41, 1'b0);
      lsend(8'hA5, 1'b1);
      @(posedge clk) t_valid <= 0;
      repeat (64) @(posedge clk);
      cmp(prx.pop_front(), 9'h141);
      cmp(prx.pop_front(), 9'h0A5);
      cmp(9'(n_end), 9'h1);
      $display("test link_send done");
      psend(KIND_DATA, 8'hC3, 1'b0);
      psend(KIND_DATA, 8'h96, 1'b1);
      for (int k = 0; k < 3; k++) psend(send_kind_type'(k), 8'(8'h5A + k), 1'b1);
      @(posedge clk) s_valid <= 0;
      repeat (80) @(posedge clk);
      foreach (ex[i]) cmp(lrx.pop_front(), ex[i]);
      $display("test phy_send done");
      // A command started as the transceiver turns the bus must be dropped by the link.
      fork
         psend(KIND_DATA, 8'h77, 1'b0);
         lsend(8'h42, 1'b1);
      join
      @(posedge clk) {abort, t_valid} <= 2'b10;
      for (int i = 0; i < 400 && ab_seen !== 1; i++) @(negedge clk);
      @(posedge clk) {abort, s_valid} <= 2'b00;
      for (int i = 0; i < 400 && owns !== 0; i++) @(negedge clk);
      cmp(9'(n_abort), 9'h1);
      cmp(9'(n_drop), 9'h1);
      cmp(ulpi_if_inst.dir, 9'h0);
      $display("test abort done");
      // First pass enters low power, second pass the three-pin serial mode.
      for (int m = 0; m < 2; m++) begin
         @(posedge clk) {ls, irq, lp_req, ser} <= {3'b101, m == 0, m == 1};
         for (int i = 0; i < 400 && sync !== 0; i++) @(negedge clk);
         repeat (64) @(negedge clk);
         cmp({ulpi_if_inst.dir, ulpi_if_inst.nxt, ulpi_if_inst.data}, 9'h02A);
         @(posedge clk) {lp_req, ser, abort} <= 3'b001;
         for (int i = 0; i < 400 && sync !== 1; i++) @(negedge clk);
         @(posedge clk) abort <= 0;
         cmp(sync, 9'h1);
      end
      $display("test low_power done");
      give_verdict;
   end
endmodule : ulpi_synchronous_mode_port_test
